// File: logic/dac_device_end.sv
`timescale 1ns/1ns
// Operation
// - Speed mode chosen from master/frame ratio
// - Source keeps rate inside selected mode
// - Source gives synchronous frame, listed ratios
// - Divide bit needed for high ratios
// - Two silent frames revert to internal
// - Internal bit clock 32/48/64 per frame
// - Sixteen edges in a phase select external
// - Internal mode acts like synchronized external
// - Three-bit field selects audio format
// - De-emphasis selects 32/44.1/48 filter
// - De-emphasis only in single speed
// - Reset holds defaults, reference low
// - Stay low power until power-down cleared
// - Clearing power-down starts timed power-up
// - Clamp 1000 frames, ramp 10000 frames
// - Reset or power-down stops audio, discharges
// - Ramp triggered by reset, no extra input; here reset only discharges and the ramp waits for power-down to be cleared
// - Mute output high in listed conditions
// - Source sends two's complement samples
module dac_device_end import dac_seq_pkg::*; #(
  parameter int CLAMP_FRAMES_P = CLAMP_FRAMES,
  parameter int RAMP_FRAMES_P = RAMP_FRAMES
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  audio_link_if.dev link,
  output logic [23:0] left_output,
  output logic [23:0] right_output,
  output logic frame_valid,
  output out_state_t out_state,
  output logic [13:0] ramp_level,
  output logic quiescent_reference,
  output logic speed_double,
  output logic ratio_valid,
  output logic bclk_external,
  output logic [1:0] deemph_filter
);
  typedef enum logic [2:0] {
    P_OFF = 3'b000, P_FAST = 3'b001, P_CLAMP = 3'b010, P_RAMP = 3'b011, P_ON = 3'b100
  } pwr_t;

  logic mck_ff, frm_ff, bck_ff;
  logic [7:0] mclk_reg_ff, mode_reg_ff;
  logic mute_a_ff, mute_b_ff;
  logic [10:0] mck_cnt_ff, ratio_ff, ib_cnt_ff;
  logic meas_ff, ext_ff, seen_ff;
  logic [4:0] ph_edges_ff;
  logic [1:0] miss_ff;
  logic [31:0] sr_ff;
  logic [5:0] bit_cnt_ff;
  logic [23:0] left_ff, right_ff;
  logic fv_ff;
  pwr_t st_ff, nxt_st;
  logic [13:0] tmr_ff, nxt_tmr;

  wire hold = !link.dac_reset_b;
  wire mck_rise = link.master_clock & ~mck_ff;
  wire frm_rise = link.frame_clock_in & ~frm_ff;
  wire frm_edge = link.frame_clock_in ^ frm_ff;
  wire bck_rise = link.bit_clock & ~bck_ff;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      mck_ff <= 1'b0;
      frm_ff <= 1'b0;
      bck_ff <= 1'b0;
    end else begin
      mck_ff <= link.master_clock;
      frm_ff <= link.frame_clock_in;
      bck_ff <= link.bit_clock;
    end
  end

  wire wr_mclk = link.reg_wr && link.reg_addr == REG_MCLK;
  wire wr_mode = link.reg_wr && link.reg_addr == REG_MODE;
  wire wr_vola = link.reg_wr && link.reg_addr == REG_VOL_A;
  wire wr_volb = link.reg_wr && link.reg_addr == REG_VOL_B;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      mclk_reg_ff <= MCLK_RST;
      mode_reg_ff <= MODE_RST;
      mute_a_ff <= VOL_RST[MUTE_BIT];
      mute_b_ff <= VOL_RST[MUTE_BIT];
    end else if (hold) begin
      mclk_reg_ff <= MCLK_RST;
      mode_reg_ff <= MODE_RST;
      mute_a_ff <= VOL_RST[MUTE_BIT];
      mute_b_ff <= VOL_RST[MUTE_BIT];
    end else begin
      if (wr_mclk) mclk_reg_ff <= link.reg_wdata;
      if (wr_mode) mode_reg_ff <= link.reg_wdata;
      if (wr_vola) mute_a_ff <= link.reg_wdata[MUTE_BIT];
      if (wr_volb) mute_b_ff <= link.reg_wdata[MUTE_BIT];
    end
  end

  wire div_bit = mclk_reg_ff[DIV_BIT];
  wire power_down_bit = mode_reg_ff[PDN_BIT];
  wire por = mode_reg_ff[POR_BIT];
  wire [2:0] fmt = mode_reg_ff[FMT_LSB +: 3];

  // Master clocks between frame rises; saturates at 7ff, and ratio keeps its last value while the frame clock is dead
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      mck_cnt_ff <= 11'h000;
      ratio_ff <= 11'h000;
      meas_ff <= 1'b0;
    end else if (frm_rise) begin
      ratio_ff <= mck_cnt_ff;
      mck_cnt_ff <= {10'h000, mck_rise};
      meas_ff <= 1'b1;
    end else if (mck_rise && mck_cnt_ff != 11'h7ff) begin
      mck_cnt_ff <= mck_cnt_ff + 11'h001;
    end
  end

  // High ratios only legal when halved by the divide bit
  wire [10:0] eff = div_bit ? ratio_ff >> 1 : ratio_ff;
  wire single_ok = meas_ff && (eff == R256 || eff == R384 || eff == R512);
  wire double_ok = meas_ff && (eff == R128 || eff == R192);
  assign ratio_valid = single_ok || double_ok;
  assign speed_double = double_ok;
  assign deemph_filter = single_ok ? mode_reg_ff[DEM_LSB +: 2] : 2'b00;

  // Bit-clock mode detection
  wire ext_hit = bck_rise && !frm_edge && ph_edges_ff == 5'(EXT_EDGES - 1);
  wire quiet_frame = frm_rise && !seen_ff && !bck_rise;
  wire miss_hit = quiet_frame && miss_ff == 2'(MISS_FRAMES - 1);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ext_ff <= 1'b0;
      ph_edges_ff <= 5'h00;
      miss_ff <= 2'h0;
      seen_ff <= 1'b0;
    end else begin
      if (frm_edge) ph_edges_ff <= {4'h0, bck_rise};
      else if (bck_rise && ph_edges_ff != 5'(EXT_EDGES)) ph_edges_ff <= ph_edges_ff + 5'h01;
      if (frm_rise) begin
        seen_ff <= bck_rise;
        miss_ff <= quiet_frame && !miss_hit ? miss_ff + 2'h1 : 2'h0;
      end else if (bck_rise) seen_ff <= 1'b1;
      if (ext_hit) ext_ff <= 1'b1;
      else if (miss_hit) ext_ff <= 1'b0;
    end
  end
  assign bclk_external = ext_ff;

  wire [6:0] ib_bits = (eff == R384 || eff == R192) ? BPF_48 :
                       (fmt == FMT_I2S16 || fmt == FMT_RJ16) ? BPF_32 : BPF_64;
  wire [10:0] ib_div = ib_bits == BPF_48 ? ratio_ff / 11'(BPF_48) :
                       ib_bits == BPF_32 ? ratio_ff >> 5 : ratio_ff >> 6;
  wire ib_stb = mck_rise && !frm_edge && ib_div != 11'h000 && ib_cnt_ff == ib_div - 11'h001;

  // Internal bit strobe lands on the last master clock of each bit slot
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ib_cnt_ff <= 11'h000;
    end else if (frm_edge) begin
      ib_cnt_ff <= 11'h001;
    end else if (mck_rise) begin
      ib_cnt_ff <= ib_stb ? 11'h000 : ib_cnt_ff + 11'h001;
    end
  end

  wire bit_stb = ext_ff ? bck_rise && !frm_edge : ib_stb;

  // Sample extraction at end of each frame phase
  wire [4:0] w = fmt_width(fmt);
  wire [5:0] need = {1'b0, w} + {5'h00, fmt_i2s(fmt)};
  wire [5:0] lsh = bit_cnt_ff > need ? bit_cnt_ff - need : 6'h00;
  // Short I2S phases lose the LSB, which lands past the phase edge
  wire [5:0] rsh = need > bit_cnt_ff ? need - bit_cnt_ff : 6'h00;
  wire [31:0] low = fmt_right(fmt) ? sr_ff : (sr_ff >> lsh) << rsh;
  wire [31:0] aligned = low << (5'h18 - w);
  wire phase_left = frm_ff ^ fmt_i2s(fmt);
  wire audio_on = st_ff == P_ON;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sr_ff <= 32'h0;
      bit_cnt_ff <= 6'h00;
      left_ff <= 24'h0;
      right_ff <= 24'h0;
      fv_ff <= 1'b0;
    end else begin
      fv_ff <= frm_edge && !phase_left && audio_on;
      if (!audio_on) begin
        left_ff <= 24'h0;
        right_ff <= 24'h0;
      end else if (frm_edge && phase_left) begin
        left_ff <= aligned[23:0];
      end else if (frm_edge) begin
        right_ff <= aligned[23:0];
      end
      if (frm_edge) begin
        sr_ff <= 32'h0;
        bit_cnt_ff <= 6'h00;
      end else if (bit_stb) begin
        sr_ff <= {sr_ff[30:0], link.audio_data_in};
        if (bit_cnt_ff != 6'h3f) bit_cnt_ff <= bit_cnt_ff + 6'h01;
      end
    end
  end
  assign left_output = left_ff;
  assign right_output = right_ff;
  assign frame_valid = fv_ff;

  // Power sequencer
  always_comb begin
    nxt_st = st_ff;
    nxt_tmr = tmr_ff;
    unique case (st_ff)
      P_OFF: begin
        if (!power_down_bit) begin
          nxt_st = por ? P_CLAMP : P_FAST;
          nxt_tmr = 14'h0000;
        end
      end
      P_FAST: begin
        nxt_tmr = tmr_ff + 14'h0001;
        if (tmr_ff == 14'(FAST_UP_CYC - 1)) nxt_st = P_ON;
      end
      P_CLAMP: begin
        if (frm_rise) begin
          nxt_tmr = tmr_ff + 14'h0001;
          if (tmr_ff == 14'(CLAMP_FRAMES_P - 1)) begin
            nxt_st = P_RAMP;
            nxt_tmr = 14'h0000;
          end
        end
      end
      P_RAMP: begin
        if (frm_rise) begin
          nxt_tmr = tmr_ff + 14'h0001;
          if (tmr_ff == 14'(RAMP_FRAMES_P - 1)) nxt_st = P_ON;
        end
      end
      P_ON: nxt_st = P_ON;
      default: nxt_st = P_OFF;
    endcase
    if (power_down_bit) nxt_st = P_OFF;
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= P_OFF;
      tmr_ff <= 14'h0000;
    end else if (hold) begin
      st_ff <= P_OFF;
      tmr_ff <= 14'h0000;
    end else begin
      st_ff <= nxt_st;
      tmr_ff <= nxt_tmr;
    end
  end

  assign quiescent_reference = st_ff != P_OFF;
  assign out_state = st_ff == P_ON ? OUT_AUDIO :
                     st_ff == P_CLAMP ? OUT_CLAMP :
                     st_ff == P_OFF ? OUT_DISCHARGE : OUT_RAMP;
  assign ramp_level = st_ff == P_RAMP ? tmr_ff :
                      st_ff == P_ON ? 14'(RAMP_FRAMES_P) : 14'h0000;
  assign link.power_up_done = audio_on;
  assign link.mute_ctrl_out = hold || !audio_on || mute_a_ff || mute_b_ff ||
                              !ratio_valid;
endmodule

// File: logic/dac_seq_pkg.sv
package dac_seq_pkg;
  localparam int SYS_CLK_HZ = 25_000_000;
  localparam int FAST_UP_US = 50;
  localparam int FAST_UP_CYC = FAST_UP_US * (SYS_CLK_HZ / 1_000_000);
  localparam int CLAMP_FRAMES = 1000;
  localparam int RAMP_FRAMES = 10000;
  localparam int EXT_EDGES = 16;
  localparam int MISS_FRAMES = 2;

  // Device register indices and fields
  localparam logic [2:0] REG_MCLK = 3'h0;
  localparam logic [2:0] REG_MODE = 3'h1;
  localparam logic [2:0] REG_VOL_A = 3'h3;
  localparam logic [2:0] REG_VOL_B = 3'h4;
  localparam int DIV_BIT = 1;
  localparam int PDN_BIT = 0;
  localparam int POR_BIT = 1;
  localparam int DEM_LSB = 2;
  localparam int FMT_LSB = 4;
  localparam int MUTE_BIT = 7;
  localparam logic [7:0] MCLK_RST = 8'h00;
  localparam logic [7:0] MODE_RST = 8'h83;
  localparam logic [7:0] VOL_RST = 8'h00;

  // Controller registers
  localparam logic [2:0] HREG_CTRL = 3'h0;
  localparam logic [2:0] HREG_TXL = 3'h1;
  localparam logic [2:0] HREG_TXR = 3'h2;
  localparam logic [2:0] HREG_DACW = 3'h3;
  localparam logic [2:0] HREG_STAT = 3'h4;
  localparam int C_REL_BIT = 0;
  localparam int C_BCLK_BIT = 1;
  localparam int C_RATIO_LSB = 2;
  localparam int C_BPF_LSB = 5;
  localparam int C_FMT_LSB = 7;
  localparam logic [9:0] CTRL_RST = 10'h04a;

  localparam logic [10:0] R128 = 11'h080;
  localparam logic [10:0] R192 = 11'h0c0;
  localparam logic [10:0] R256 = 11'h100;
  localparam logic [10:0] R384 = 11'h180;
  localparam logic [10:0] R512 = 11'h200;
  localparam logic [10:0] R768 = 11'h300;
  localparam logic [10:0] R1024 = 11'h400;
  localparam logic [6:0] BPF_32 = 7'h20;
  localparam logic [6:0] BPF_48 = 7'h30;
  localparam logic [6:0] BPF_64 = 7'h40;

  typedef enum logic [2:0] {
    FMT_LJ24 = 3'b000, FMT_I2S16 = 3'b001, FMT_I2S24 = 3'b010, FMT_RJ16 = 3'b011,
    FMT_RJ24 = 3'b100, FMT_RJ20 = 3'b101, FMT_RJ18 = 3'b110, FMT_RSVD = 3'b111
  } fmt_t;

  typedef enum logic [1:0] {
    OUT_DISCHARGE = 2'b00, OUT_CLAMP = 2'b01, OUT_RAMP = 2'b10, OUT_AUDIO = 2'b11
  } out_state_t;

  function automatic logic [4:0] fmt_width(input logic [2:0] f);
    case (f)
      FMT_I2S16, FMT_RJ16: fmt_width = 5'h10;
      FMT_RJ20: fmt_width = 5'h14;
      FMT_RJ18: fmt_width = 5'h12;
      default: fmt_width = 5'h18;
    endcase
  endfunction

  function automatic logic fmt_i2s(input logic [2:0] f);
    fmt_i2s = (f == FMT_I2S16) || (f == FMT_I2S24);
  endfunction

  function automatic logic fmt_right(input logic [2:0] f);
    fmt_right = (f >= FMT_RJ16) && (f <= FMT_RJ18);
  endfunction
endpackage

// File: logic/audio_link_if.sv
`timescale 1ns/1ns
interface audio_link_if;
  logic master_clock;
  logic frame_clock_in;
  logic bit_clock;
  logic audio_data_in;
  logic dac_reset_b;
  logic reg_wr;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata;
  logic mute_ctrl_out;
  logic power_up_done;

  modport dev (
    input master_clock, frame_clock_in, bit_clock, audio_data_in,
    input dac_reset_b, reg_wr, reg_addr, reg_wdata,
    output mute_ctrl_out, power_up_done
  );
  modport src (
    output master_clock, frame_clock_in, bit_clock, audio_data_in,
    output dac_reset_b, reg_wr, reg_addr, reg_wdata,
    input mute_ctrl_out, power_up_done
  );
endinterface

// File: logic/audio_source_end.sv
`timescale 1ns/1ns
module audio_source_end import dac_seq_pkg::*; (
  input wire logic sys_clk,
  input wire logic rst_b,
  audio_link_if.src link,
  input wire logic [2:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata
);
  logic [9:0] ctrl_ff;
  logic [23:0] txl_ff, txr_ff;
  logic dwr_ff;
  logic [2:0] dadr_ff;
  logic [7:0] ddat_ff;
  logic [31:0] rdata_ff;
  logic mclk_ff, frm_ff, bclk_ff, data_ff;
  logic [10:0] m_cnt_ff, bdiv_ff;
  logic [5:0] bitk_ff;

  wire wr_ctrl = wr && addr == HREG_CTRL;
  wire wr_txl = wr && addr == HREG_TXL;
  wire wr_txr = wr && addr == HREG_TXR;
  wire wr_dacw = wr && addr == HREG_DACW;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_ff <= CTRL_RST;
      txl_ff <= 24'h0;
      txr_ff <= 24'h0;
      dwr_ff <= 1'b0;
      dadr_ff <= 3'h0;
      ddat_ff <= 8'h00;
    end else begin
      if (wr_ctrl) ctrl_ff <= wdata[9:0];
      if (wr_txl) txl_ff <= wdata[23:0];
      if (wr_txr) txr_ff <= wdata[23:0];
      dwr_ff <= wr_dacw;
      if (wr_dacw) begin
        dadr_ff <= wdata[10:8];
        ddat_ff <= wdata[7:0];
      end
    end
  end

  wire [31:0] rd_mux = addr == HREG_CTRL ? {22'h0, ctrl_ff} :
                       addr == HREG_TXL ? {8'h00, txl_ff} :
                       addr == HREG_TXR ? {8'h00, txr_ff} :
                       addr == HREG_STAT ? {30'h0, link.power_up_done, link.mute_ctrl_out} :
                       32'h0;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) rdata_ff <= 32'h0;
    else if (rd) rdata_ff <= rd_mux;
    else rdata_ff <= 32'h0;
  end
  assign rdata = rdata_ff;

  function automatic logic [10:0] ratio_of(input logic [2:0] c);
    case (c)
      3'h0: ratio_of = R128;
      3'h1: ratio_of = R192;
      3'h2: ratio_of = R256;
      3'h3: ratio_of = R384;
      3'h4: ratio_of = R512;
      3'h5: ratio_of = R768;
      default: ratio_of = R1024;
    endcase
  endfunction

  wire [2:0] fmt = ctrl_ff[C_FMT_LSB +: 3];
  wire [10:0] m = ratio_of(ctrl_ff[C_RATIO_LSB +: 3]);
  wire [1:0] bc = ctrl_ff[C_BPF_LSB +: 2];
  wire [6:0] n = bc == 2'h0 ? BPF_32 : bc == 2'h1 ? BPF_48 : BPF_64;
  wire [10:0] d = bc == 2'h1 ? m / 11'(BPF_48) : bc == 2'h0 ? m >> 5 : m >> 6;
  wire [10:0] half = m >> 1;
  wire tick = !mclk_ff;
  wire [10:0] nxt_m = m_cnt_ff >= m - 11'h001 ? 11'h000 : m_cnt_ff + 11'h001;
  wire ph_start = nxt_m == 11'h000 || nxt_m == half;
  wire bit_end = bdiv_ff >= d - 11'h001;
  wire [10:0] nxt_bdiv = ph_start || bit_end ? 11'h000 : bdiv_ff + 11'h001;
  wire [5:0] nxt_bitk = ph_start ? 6'h00 : bit_end ? bitk_ff + 6'h01 : bitk_ff;
  wire nxt_frm = nxt_m < half;
  wire [23:0] samp = (nxt_frm ^ fmt_i2s(fmt)) ? txl_ff : txr_ff;
  wire [4:0] w = fmt_width(fmt);
  wire [5:0] start = fmt_right(fmt) ? (n[6:1] > {1'b0, w} ? n[6:1] - {1'b0, w} : 6'h00) :
                     {5'h00, fmt_i2s(fmt)};
  wire [5:0] j = nxt_bitk - start;
  wire in_word = nxt_bitk >= start && j < {1'b0, w};
  wire [4:0] pos = 5'h17 - j[4:0];
  wire nxt_data = in_word && samp[pos];

  // Clocks advance together on each master clock rise, keeping frames synchronous
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      mclk_ff <= 1'b0;
      frm_ff <= 1'b0;
      bclk_ff <= 1'b0;
      data_ff <= 1'b0;
      m_cnt_ff <= 11'h000;
      bdiv_ff <= 11'h000;
      bitk_ff <= 6'h00;
    end else begin
      mclk_ff <= !mclk_ff;
      if (tick) begin
        m_cnt_ff <= nxt_m;
        bdiv_ff <= nxt_bdiv;
        bitk_ff <= nxt_bitk;
        frm_ff <= nxt_frm;
        bclk_ff <= ctrl_ff[C_BCLK_BIT] && nxt_bdiv >= (d >> 1);
        if (nxt_bdiv == 11'h000) data_ff <= nxt_data;
      end
    end
  end

  assign link.master_clock = mclk_ff;
  assign link.frame_clock_in = frm_ff;
  assign link.bit_clock = bclk_ff;
  assign link.audio_data_in = data_ff;
  assign link.dac_reset_b = ctrl_ff[C_REL_BIT];
  assign link.reg_wr = dwr_ff;
  assign link.reg_addr = dadr_ff;
  assign link.reg_wdata = ddat_ff;
endmodule

// File: verif/dac_seq_props.sv
`timescale 1ns/1ns
module dac_seq_props import dac_seq_pkg::*; #(
  parameter int CLAMP_FRAMES_P = CLAMP_FRAMES,
  parameter int RAMP_FRAMES_P = RAMP_FRAMES
) (
  input logic sys_clk,
  input logic rst_b,
  input logic master_clock,
  input logic frame_clock_in,
  input logic dac_reset_b,
  input logic reg_wr,
  input logic [2:0] reg_addr,
  input logic [7:0] reg_wdata,
  input logic mute_ctrl_out,
  input logic power_up_done
);
  localparam int SLOW = CLAMP_FRAMES_P + RAMP_FRAMES_P;
  logic fr_d_ff, mc_d_ff, seen_ff, div_ff, fast_ff;
  logic [1:0] chm_ff;
  logic [10:0] mcnt_ff;
  logic [15:0] cyc_ff, frm_ff;
  wire fr_rise = frame_clock_in && !fr_d_ff;
  wire mc_rise = master_clock && !mc_d_ff;
  // Count includes a master rise landing on the frame edge itself
  wire [10:0] full = mcnt_ff + {10'h0, mc_rise};
  wire [10:0] eff = div_ff ? (full >> 1) : full;
  wire ok_ratio = (eff == R128) || (eff == R192) || (eff == R256) || (eff == R384) ||
                  (eff == R512);
  wire mode_wr = reg_wr && dac_reset_b && (reg_addr == REG_MODE);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      fr_d_ff <= 1'b0;
      mc_d_ff <= 1'b0;
      mcnt_ff <= 11'h0;
      seen_ff <= 1'b0;
    end else begin
      fr_d_ff <= frame_clock_in;
      mc_d_ff <= master_clock;
      mcnt_ff <= fr_rise ? 11'h0 : full;
      seen_ff <= seen_ff | fr_rise;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      div_ff <= 1'b0;
      chm_ff <= 2'h0;
    end else if (!dac_reset_b) begin
      div_ff <= 1'b0;
      chm_ff <= 2'h0;
    end else if (reg_wr) begin
      div_ff <= (reg_addr == REG_MCLK) ? reg_wdata[DIV_BIT] : div_ff;
      chm_ff[0] <= (reg_addr == REG_VOL_A) ? reg_wdata[MUTE_BIT] : chm_ff[0];
      chm_ff[1] <= (reg_addr == REG_VOL_B) ? reg_wdata[MUTE_BIT] : chm_ff[1];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      fast_ff <= 1'b0;
      cyc_ff <= 16'h0;
      frm_ff <= 16'h0;
    end else if (mode_wr) begin
      fast_ff <= !reg_wdata[POR_BIT];
      cyc_ff <= 16'h0;
      frm_ff <= 16'h0;
    end else begin
      cyc_ff <= cyc_ff + {15'h0, cyc_ff != 16'hffff};
      frm_ff <= frm_ff + {15'h0, fr_rise};
    end
  end

  sequence s_bad_frame;
    fr_rise && seen_ff && !ok_ratio;
  endsequence
  sequence s_pdn_set;
    mode_wr && reg_wdata[PDN_BIT];
  endsequence
  sequence s_release;
    $rose(dac_reset_b);
  endsequence

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  a_reset_mutes: assert property (!dac_reset_b |=> mute_ctrl_out && !power_up_done)
    else $error("mute or done wrong during device reset");
  a_idle_mutes: assert property (!power_up_done |-> mute_ctrl_out)
    else $error("mute low outside audio");
  a_pdn_stops: assert property (s_pdn_set |-> ##3 !power_up_done)
    else $error("audio kept after power-down");
  a_hold_low: assert property (s_release |-> !power_up_done [*8])
    else $error("power-up without host order");
  a_fast_time: assert property ($rose(power_up_done) && fast_ff |->
    cyc_ff >= FAST_UP_CYC - 6 && cyc_ff <= FAST_UP_CYC + 6)
    else $error("fast power-up length wrong");
  a_ramp_frames: assert property ($rose(power_up_done) && !fast_ff |->
    frm_ff >= SLOW - 1 && frm_ff <= SLOW + 2)
    else $error("soft ramp length wrong");
  a_bad_ratio: assert property (s_bad_frame |-> ##3 mute_ctrl_out)
    else $error("mute low on invalid clock ratio");
  a_chan_mute: assert property (chm_ff != 2'h0 |-> mute_ctrl_out)
    else $error("mute low with channel muted");
endmodule

// File: verif/dac_clocking_and_power_sequencer_test.sv
`timescale 1ns/1ns
module dac_clocking_and_power_sequencer_test import dac_seq_pkg::*;;
  localparam int CF = 4;
  localparam int RF = 8;
  localparam int LIMIT = 90000;
  logic sys_clk, rst_b, wr, rd, frame_valid, quiescent_reference;
  logic speed_double, ratio_valid, bclk_external;
  logic [2:0] addr;
  logic [31:0] wdata, rdata, rv;
  logic [23:0] left_output, right_output;
  logic [13:0] ramp_level;
  logic [1:0] deemph_filter;
  logic [10:0] rtab [7] = '{R128, R192, R256, R384, R512, R768, R1024};
  out_state_t out_state;
  int fail_count, tests_run, cycles, n, f;

  audio_link_if link();
  dac_device_end #(.CLAMP_FRAMES_P(CF), .RAMP_FRAMES_P(RF)) dac_device_end_inst (
    .sys_clk(sys_clk), .rst_b(rst_b), .link(link), .left_output(left_output),
    .right_output(right_output), .frame_valid(frame_valid), .out_state(out_state),
    .ramp_level(ramp_level), .quiescent_reference(quiescent_reference),
    .speed_double(speed_double), .ratio_valid(ratio_valid),
    .bclk_external(bclk_external), .deemph_filter(deemph_filter));
  audio_source_end audio_source_end_inst (.sys_clk(sys_clk), .rst_b(rst_b), .link(link),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  dac_seq_props #(.CLAMP_FRAMES_P(CF), .RAMP_FRAMES_P(RF)) dac_seq_props_inst (
    .sys_clk(sys_clk), .rst_b(rst_b), .master_clock(link.master_clock),
    .frame_clock_in(link.frame_clock_in), .dac_reset_b(link.dac_reset_b),
    .reg_wr(link.reg_wr), .reg_addr(link.reg_addr), .reg_wdata(link.reg_wdata),
    .mute_ctrl_out(link.mute_ctrl_out), .power_up_done(link.power_up_done));

  task automatic tally_and_finish;
    $display("Checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  task automatic hwr(input logic [2:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask
  task automatic hrd(input logic [2:0] a);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1 rv = rdata;
  endtask
  // Device write crosses the controller, so allow its pipeline to land
  task automatic dw(input logic [2:0] i, input logic [7:0] d);
    hwr(HREG_DACW, {21'h0, i, d});
    repeat (5) @(posedge sys_clk);
    #1;
  endtask
  function automatic logic [31:0] cw(input logic [2:0] r, input logic b,
                                     input logic [1:0] p, input logic [2:0] fm);
    cw = {22'h0, fm, p, r, b, 1'b1};
  endfunction
  task automatic wfr(input int k);
    repeat (k) @(posedge link.frame_clock_in);
    repeat (3) @(posedge sys_clk);
    #1;
  endtask
  task automatic wst(input out_state_t s, input int lim);
    logic p;
    n = 0;
    f = 0;
    p = link.frame_clock_in;
    while (out_state !== s && n < lim) begin
      @(posedge sys_clk);
      #1;
      n++;
      f += int'(link.frame_clock_in && !p);
      p = link.frame_clock_in;
    end
  endtask
  task automatic wfv(input int k);
    repeat (k) begin
      n = 0;
      do begin
        @(posedge sys_clk);
        #1;
        n++;
      end while (frame_valid !== 1'b1 && n < 3000);
    end
  endtask

  task automatic t_reset;
    hwr(3'h6, 32'hffffffff);
    hrd(HREG_CTRL);
    chk(rv === {22'h0, CTRL_RST}, "controller reset value");
    hrd(3'h7);
    chk(rv === 32'h0, "unmapped read");
    hrd(HREG_STAT);
    chk(rv === 32'h1, "status in reset");
    chk(quiescent_reference === 1'b0 && out_state === OUT_DISCHARGE, "reference up");
  endtask
  task automatic t_ratio;
    logic [2:0] cd [10];
    logic dv [10];
    logic [10:0] e;
    logic [1:0] dm;
    logic vs, vd;
    cd = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h5, 3'h6, 3'h2, 3'h6};
    dv = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
    for (int i = 0; i < 10; i++) begin
      dm = 2'(i % 3 + 1);
      hwr(HREG_CTRL, cw(cd[i], 1'b1, 2'h2, FMT_LJ24));
      dw(REG_MCLK, {6'h0, dv[i], 1'b0});
      dw(REG_MODE, {4'h0, dm, 2'h3});
      e = dv[i] ? rtab[cd[i]] >> 1 : rtab[cd[i]];
      vd = (e == R128) || (e == R192);
      vs = (e == R256) || (e == R384) || (e == R512);
      wfr(3);
      chk(ratio_valid === (vs | vd), "ratio class");
      if (vs | vd) begin
        chk(speed_double === vd, "speed mode");
        chk(deemph_filter === (vd ? 2'h0 : dm), "de-emphasis");
        chk(bclk_external === 1'b1, "external bit clock");
      end else begin
        hrd(HREG_STAT);
        chk(rv[0] === 1'b1, "mute on bad ratio");
      end
    end
  endtask
  task automatic t_bclk;
    hwr(HREG_CTRL, cw(3'h2, 1'b0, 2'h0, FMT_RJ16));
    dw(REG_MCLK, 8'h00);
    wfr(4);
    chk(bclk_external === 1'b0, "internal after silence");
    hwr(HREG_CTRL, cw(3'h2, 1'b1, 2'h0, FMT_RJ16));
    wfr(2);
    chk(bclk_external === 1'b1, "sixteen edges per phase");
    // Stop mid-frame so the current frame still holds edges
    repeat (128) @(posedge sys_clk);
    hwr(HREG_CTRL, cw(3'h2, 1'b0, 2'h0, FMT_RJ16));
    wfr(2);
    chk(bclk_external === 1'b1, "one silent frame");
    wfr(2);
    chk(bclk_external === 1'b0, "two silent frames");
  endtask
  task automatic t_fast;
    hwr(HREG_CTRL, cw(3'h2, 1'b0, 2'h2, FMT_LJ24));
    hwr(HREG_TXL, 32'h009abcde);
    hwr(HREG_TXR, 32'h003c5a71);
    dw(REG_MODE, 8'h01);
    repeat (100) @(posedge sys_clk);
    chk(out_state === OUT_DISCHARGE && quiescent_reference === 1'b0, "low power");
    hwr(HREG_DACW, {21'h0, REG_MODE, 8'h00});
    wst(OUT_AUDIO, 3000);
    chk(n >= FAST_UP_CYC - 6 && n <= FAST_UP_CYC + 10, "fast power-up");
    hrd(HREG_STAT);
    chk(rv === 32'h2, "done and unmuted");
  endtask
  // Internal bit clock throughout: source rate follows the internal ratio table
  task automatic t_fmt;
    logic [4:0] w [7];
    logic [23:0] m;
    w = '{5'h18, 5'h10, 5'h18, 5'h10, 5'h18, 5'h14, 5'h12};
    for (int i = 0; i < 7; i++) begin
      hwr(HREG_CTRL, cw(3'h2, 1'b0, (w[i] == 5'h10) ? 2'h0 : 2'h2, 3'(i)));
      dw(REG_MODE, {1'b0, 3'(i), 4'h0});
      m = 24'hffffff << (5'h18 - w[i]);
      wfv(3);
      chk(left_output === (24'h9abcde & m) && right_output === (24'h3c5a71 & m),
          "sample capture");
    end
  endtask
  task automatic t_down;
    dw(REG_VOL_B, 8'h80);
    hrd(HREG_STAT);
    chk(rv === 32'h3, "channel mute");
    dw(REG_VOL_B, 8'h00);
    dw(REG_MODE, 8'h01);
    chk(out_state === OUT_DISCHARGE && left_output === 24'h0, "power-down");
  endtask
  task automatic t_soft;
    hwr(HREG_DACW, {21'h0, REG_MODE, 8'h02});
    wst(OUT_CLAMP, 20);
    chk(out_state === OUT_CLAMP, "clamp first");
    wst(OUT_RAMP, 8000);
    chk(f >= CF - 1 && f <= CF + 1, "clamp length");
    hrd(HREG_STAT);
    chk(rv === 32'h1, "done during ramp");
    wst(OUT_AUDIO, 8000);
    chk(f >= RF - 1 && f <= RF + 1 && ramp_level === 14'(RF), "ramp length");
    hwr(HREG_CTRL, cw(3'h2, 1'b0, 2'h2, FMT_LJ24) & 32'hfffffffe);
    repeat (4) @(posedge sys_clk);
    #1;
    chk(out_state === OUT_DISCHARGE && quiescent_reference === 1'b0, "reset");
    hrd(HREG_STAT);
    chk(rv === 32'h1, "mute in reset");
    hwr(HREG_CTRL, cw(3'h2, 1'b0, 2'h2, FMT_LJ24));
    repeat (300) @(posedge sys_clk);
    #1;
    chk(out_state === OUT_DISCHARGE, "defaults after reset");
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      fail_count++;
      $display("MISMATCH %0t run too long", $time);
      tally_and_finish();
    end
  end
  initial begin
    rst_b = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 3'h0;
    wdata = 32'h0;
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_reset();
    t_ratio();
    t_bclk();
    t_fast();
    t_fmt();
    t_down();
    t_soft();
    tally_and_finish();
  end
endmodule
